// *** rtl/sar_adc_pkg.sv ***
package sar_adc_pkg;

  localparam int unsigned DATA_W          = 8;
  localparam int unsigned CHAN_N          = 4;
  localparam int unsigned PADDR_W         = 7;
  localparam int unsigned RFADDR_W        = 7;

  localparam logic [PADDR_W-1:0]  DATA_PADDR   = 7'h04;
  localparam logic [RFADDR_W-1:0] START_RFADDR = 7'h20;
  localparam int unsigned         START_BIT    = 0;

  localparam logic [DATA_W-1:0]   DATA_RESET   = 8'h00;
  localparam logic [3:0]          NIBBLE_RESET = 4'h0;
  localparam logic [15:0]         DBF_RESET    = 16'h0000;

  // Instruction times spent on each decision
  localparam int unsigned         INSTR_PER_BIT = 3;
  localparam logic [2:0]          MSB_INDEX     = 3'h7;

  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [PADDR_W-1:0]  addr;
    logic [15:0]         wdata;
  } periph_req_s;

  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [RFADDR_W-1:0] addr;
    logic [3:0]          wdata;
  } rf_req_s;

endpackage : sar_adc_pkg

// *** rtl/level_sync.sv ***
`timescale 1ns/100ps
module level_sync
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  // First stage feeds only the second
  always_comb
  begin
    next_stage1   = ce ? async_in : stage1;
    next_sync_out = ce ? stage1 : sync_out;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule : level_sync

// *** rtl/instr_counter.sv ***
`timescale 1ns/100ps
module instr_counter
#(
  parameter int unsigned COUNT = 3
)
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic clear,
  input  wire logic advance,
  output logic      expired
);

  logic [1:0] cnt;
  logic [1:0] next_cnt;

  assign expired = advance && !clear
                   && (cnt == 2'(COUNT - 1));

  always_comb
  begin
    next_cnt = cnt;
    if (ce)
    begin
      if (clear || expired)
        next_cnt = 2'h0;
      else if (advance)
        next_cnt = cnt + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnt <= 2'h0;
    else
      cnt <= next_cnt;
  end

endmodule : instr_counter

// *** rtl/sar_adc_sequencer.sv ***
`timescale 1ns/100ps
//
// Summary of operation
// - Eight-bit successive-approximation conversion of one of four inputs.
// - Mode select 0 gives successive conversion, 1 gives single compare.
// - Successive mode resolves the result from the MSB downward.
// - Comparator decision is 1 when input exceeds DAC voltage, else 0.
// - Successive decisions go to data register; single ones to compare flag.
// - Single mode data register drives DAC; successive mode it accumulates.
// - Stop clears the conversion data register to zero.
// - Stop aborts conversion, resets converter, cuts supply; stays stopped.
// - Halt suspends conversion with supply on; resumes on release.
// - Successive mode supply runs from start flag until done flag sets.
// - Single mode supply runs from start or data write until result latched.
// - Writing the data register clears the compare result flag.
// - Start flag at bit 0 resets to 0, self-clears; upper bits read 0.
// - Setting start clears data register; successive mode also sets the MSB, giving 8'h80.
// - Data register write takes only the low 8 buffer bits.
// - Data register read loads low 8 bits, keeps high buffer byte.
// - Data register writes are ignored while mode select is 0.
// - Each bit takes three instruction times; done sets when LSB stored.
// - A two-bit channel select field picks the analog input.
//
module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  input  wire logic                          SYS_CLK,
  input  wire logic                          RSTN,
  input  wire logic                          CLK_EN,
  input  wire logic                          INSTR_TICK,
  input  wire logic                          HALT_MODE,
  input  wire logic                          STOP_MODE,
  input  wire logic                          COMPARE_MODE_SELECT,
  input  wire logic                          CHANNEL_SELECT_HI,
  input  wire logic                          CHANNEL_SELECT_LO,
  input  wire sar_adc_pkg::periph_req_s      PERIPH_REQ,
  input  wire logic [15:0]                   DATA_BUFFER_PAIR,
  input  wire sar_adc_pkg::rf_req_s          RF_REQ,
  input  wire logic                          COMPARATOR_IN,
  output logic [15:0]                        PERIPH_RDATA,
  output logic [3:0]                         RF_RDATA,
  output logic                               CONVERSION_DONE_FLAG,
  output logic                               COMPARE_RESULT_FLAG,
  output logic [sar_adc_pkg::DATA_W-1:0]     DAC_CODE,
  output logic [sar_adc_pkg::CHAN_N-1:0]     CHANNEL_ENABLE,
  output logic                               SUPPLY_ENABLE
);

  import sar_adc_pkg::*;

  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b001,
    ST_CONVERT = 3'b010,
    ST_COMPARE = 3'b100
  } seq_state_e;

  seq_state_e        state;
  seq_state_e        next_state;
  logic [DATA_W-1:0] conversion_data;
  logic [DATA_W-1:0] next_conversion_data;
  logic [2:0]        bit_index;
  logic [2:0]        next_bit_index;
  logic              conversion_start_flag;
  logic              next_conversion_start_flag;
  logic              next_done_flag;
  logic              next_compare_flag;
  logic              next_supply;
  logic [15:0]       next_periph_rdata;
  logic [3:0]        next_rf_rdata;
  logic [CHAN_N-1:0] next_channel_enable;
  logic              decision;
  logic              data_write;
  logic              data_read;
  logic              start_write;
  logic              start_read;
  logic              running;
  logic              step_clear;
  logic              step_done;

  // Comparator output comes from the analog side, so it is resynchronised
  level_sync u_cmp_sync
  (
    .clk      (SYS_CLK),
    .rstn     (RSTN),
    .ce       (CLK_EN),
    .async_in (COMPARATOR_IN),
    .sync_out (decision)
  );

  assign running    = (state != ST_IDLE);
  assign step_clear = (state == ST_IDLE) || STOP_MODE;

  instr_counter
  #(
    .COUNT (INSTR_PER_BIT)
  )
  u_step
  (
    .clk     (SYS_CLK),
    .rstn    (RSTN),
    .ce      (CLK_EN),
    .clear   (step_clear),
    .advance (running && INSTR_TICK && !HALT_MODE),
    .expired (step_done)
  );

  assign data_write  = PERIPH_REQ.wr && (PERIPH_REQ.addr == DATA_PADDR);
  assign data_read   = PERIPH_REQ.rd && (PERIPH_REQ.addr == DATA_PADDR);
  assign start_write = RF_REQ.wr && (RF_REQ.addr == START_RFADDR);
  assign start_read  = RF_REQ.rd && (RF_REQ.addr == START_RFADDR);

  // Sequencer state, data register, start flag and status flags
  always_comb
  begin
    next_state                 = state;
    next_conversion_data       = conversion_data;
    next_bit_index             = bit_index;
    next_conversion_start_flag = conversion_start_flag;
    next_done_flag             = CONVERSION_DONE_FLAG;
    next_compare_flag          = COMPARE_RESULT_FLAG;
    if (CLK_EN)
    begin
      if (start_write && RF_REQ.wdata[START_BIT])
        next_conversion_start_flag = 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (conversion_start_flag)
          begin
            next_conversion_start_flag = 1'b0;
            next_conversion_data = DATA_RESET;
            next_done_flag       = 1'b0;
            if (!COMPARE_MODE_SELECT)
            begin
              next_bit_index = MSB_INDEX;
              next_conversion_data[MSB_INDEX] = 1'b1;
              next_state = ST_CONVERT;
            end
            else
              next_state = ST_COMPARE;
          end
        end
        ST_CONVERT:
        begin
          if (step_done)
          begin
            next_conversion_data[bit_index] = decision;
            if (bit_index == 3'h0)
            begin
              next_done_flag = 1'b1;
              next_state     = ST_IDLE;
            end
            else
            begin
              next_bit_index = bit_index - 3'h1;
              next_conversion_data[bit_index - 3'h1] = 1'b1;
            end
          end
        end
        ST_COMPARE:
        begin
          if (step_done)
          begin
            next_compare_flag = decision;
            next_state        = ST_IDLE;
          end
        end
        default:
          next_state = ST_IDLE;
      endcase
      // A write restarts the compare, so it overrides a latch in flight
      // Write ignored in successive mode
      if (data_write && COMPARE_MODE_SELECT && !conversion_start_flag)
      begin
        next_conversion_data = DATA_BUFFER_PAIR[DATA_W-1:0];
        next_compare_flag    = 1'b0;
        next_state           = ST_COMPARE;
      end
      if (STOP_MODE)
      begin
        next_state                 = ST_IDLE;
        next_conversion_data       = DATA_RESET;
        next_conversion_start_flag = 1'b0;
      end
    end
  end

  // Read paths, supply gate and channel decode
  always_comb
  begin
    next_periph_rdata   = PERIPH_RDATA;
    next_rf_rdata       = RF_RDATA;
    next_supply         = SUPPLY_ENABLE;
    next_channel_enable = CHANNEL_ENABLE;
    if (CLK_EN)
    begin
      if (data_read)
        next_periph_rdata = {DATA_BUFFER_PAIR[15:DATA_W], conversion_data};
      if (start_read)
        next_rf_rdata = {3'h0, conversion_start_flag};
      next_supply = (next_state != ST_IDLE) && !STOP_MODE;
      next_channel_enable = CHAN_N'(1) <<
                            {CHANNEL_SELECT_HI, CHANNEL_SELECT_LO};
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      state                 <= ST_IDLE;
      conversion_data       <= DATA_RESET;
      bit_index             <= MSB_INDEX;
      conversion_start_flag <= 1'b0;
      CONVERSION_DONE_FLAG  <= 1'b0;
      COMPARE_RESULT_FLAG   <= 1'b0;
      PERIPH_RDATA          <= DBF_RESET;
      RF_RDATA              <= NIBBLE_RESET;
      SUPPLY_ENABLE         <= 1'b0;
      CHANNEL_ENABLE        <= '0;
    end
    else
    begin
      state                 <= next_state;
      conversion_data       <= next_conversion_data;
      bit_index             <= next_bit_index;
      conversion_start_flag <= next_conversion_start_flag;
      CONVERSION_DONE_FLAG  <= next_done_flag;
      COMPARE_RESULT_FLAG   <= next_compare_flag;
      PERIPH_RDATA          <= next_periph_rdata;
      RF_RDATA              <= next_rf_rdata;
      SUPPLY_ENABLE         <= next_supply;
      CHANNEL_ENABLE        <= next_channel_enable;
    end
  end

  assign DAC_CODE = conversion_data;

endmodule : sar_adc_sequencer

// *** tb/sar_adc_monitor.sv ***
`timescale 1ns/100ps
module sar_adc_monitor
  import sar_adc_pkg::*;
(
  input wire logic                     SYS_CLK,
  input wire logic                     RSTN,
  input wire logic                     HALT_MODE,
  input wire logic                     STOP_MODE,
  input wire logic                     COMPARE_MODE_SELECT,
  input wire logic                     CHANNEL_SELECT_HI,
  input wire logic                     CHANNEL_SELECT_LO,
  input wire sar_adc_pkg::periph_req_s PERIPH_REQ,
  input wire logic [15:0]              DATA_BUFFER_PAIR,
  input wire sar_adc_pkg::rf_req_s     RF_REQ,
  input wire logic [15:0]              PERIPH_RDATA,
  input wire logic [3:0]               RF_RDATA,
  input wire logic                     CONVERSION_DONE_FLAG,
  input wire logic                     COMPARE_RESULT_FLAG,
  input wire logic [7:0]               DAC_CODE,
  input wire logic [3:0]               CHANNEL_ENABLE,
  input wire logic                     SUPPLY_ENABLE
);
  logic pw;
  logic rs;
  logic quiet;
  assign pw = PERIPH_REQ.wr && PERIPH_REQ.addr == DATA_PADDR;
  assign rs = RF_REQ.wr && RF_REQ.addr == START_RFADDR && RF_REQ.wdata[0];
  assign quiet = !STOP_MODE && !HALT_MODE;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  a_stop_clears: assert property (STOP_MODE |=>
    DAC_CODE == 8'h00 && !SUPPLY_ENABLE) else $error("stop not applied");
  a_write_ignored: assert property (pw && !COMPARE_MODE_SELECT
    && !SUPPLY_ENABLE && quiet |=> $stable(DAC_CODE)) else $error("wr taken");
  a_write_loads: assert property (pw && COMPARE_MODE_SELECT && quiet |=>
    DAC_CODE == $past(DATA_BUFFER_PAIR[7:0]) && !COMPARE_RESULT_FLAG
    && SUPPLY_ENABLE) else $error("compare write wrong");
  a_start_msb: assert property (rs && !COMPARE_MODE_SELECT && quiet
    && !SUPPLY_ENABLE |=> ##1 DAC_CODE == 8'h80 && SUPPLY_ENABLE)
    else $error("start wrong");
  a_rf_upper: assert property (RF_REQ.rd && RF_REQ.addr == START_RFADDR
    |=> RF_RDATA[3:1] == 3'h0) else $error("upper bits set");
  a_read_data: assert property (PERIPH_REQ.rd
    && PERIPH_REQ.addr == DATA_PADDR |=> PERIPH_RDATA ==
    {$past(DATA_BUFFER_PAIR[15:8]), $past(DAC_CODE)}) else $error("read");
  a_done_supply: assert property ($rose(CONVERSION_DONE_FLAG)
    && !COMPARE_MODE_SELECT |-> !SUPPLY_ENABLE) else $error("supply on");
  a_chan_decode: assert property (1'b1 |=> CHANNEL_ENABLE ==
    4'h1 << {$past(CHANNEL_SELECT_HI), $past(CHANNEL_SELECT_LO)})
    else $error("channel decode");
  a_halt_keeps: assert property (HALT_MODE && SUPPLY_ENABLE
    && !STOP_MODE |=> SUPPLY_ENABLE) else $error("halt cut supply");
  cover property ($rose(CONVERSION_DONE_FLAG));
  cover property (STOP_MODE && SUPPLY_ENABLE);
  cover property (pw && COMPARE_MODE_SELECT);
endmodule : sar_adc_monitor
bind sar_adc_sequencer sar_adc_monitor i_mon (.*);

// *** tb/analog_front_model.sv ***
`timescale 1ns/100ps
module analog_front_model
(
  input  wire logic [31:0] levels,
  input  wire logic [3:0]  chan_en,
  input  wire logic [7:0]  dac_code,
  output logic             cmp_out
);
  logic [7:0] vin;
  always_comb
  begin
    vin = 8'h00;
    for (int i = 0; i < 4; i++)
      if (chan_en[i])
        vin = levels[8*i +: 8];
  end
  assign cmp_out = vin > dac_code;
endmodule : analog_front_model

// *** tb/sar_adc_sequencer_bench.sv ***
`timescale 1ns/100ps
module sar_adc_sequencer_bench;
  import sar_adc_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        tick = 1'b0;
  logic        halt = 1'b0;
  logic        stop = 1'b0;
  logic        msel = 1'b0;
  logic [1:0]  ch = 2'h0;
  periph_req_s preq = '0;
  logic [15:0] dbuf = 16'h0000;
  rf_req_s     rreq = '0;
  logic [31:0] lv = 32'h0;
  logic [1:0]  tcnt = 2'h0;
  logic        cmp;
  logic [15:0] prd;
  logic [3:0]  rrd;
  logic        done;
  logic        cres;
  logic        sup;
  logic [7:0]  dac;
  logic [3:0]  chen;
  int          miscompares = 0;
  int          comparisons = 0;
  int          seed = 45357;
  always #25 clk = ~clk;
  // Ticks every four cycles, slower than the comparator sync
  always @(negedge clk)
  begin
    tcnt <= tcnt + 2'h1;
    tick <= tcnt == 2'h3;
  end
  sar_adc_sequencer i_dut (.SYS_CLK(clk), .RSTN(rstn), .CLK_EN(1'b1),
    .INSTR_TICK(tick), .HALT_MODE(halt), .STOP_MODE(stop),
    .COMPARE_MODE_SELECT(msel), .CHANNEL_SELECT_HI(ch[1]),
    .CHANNEL_SELECT_LO(ch[0]), .PERIPH_REQ(preq), .DATA_BUFFER_PAIR(dbuf),
    .RF_REQ(rreq), .COMPARATOR_IN(cmp), .PERIPH_RDATA(prd), .RF_RDATA(rrd),
    .CONVERSION_DONE_FLAG(done), .COMPARE_RESULT_FLAG(cres),
    .DAC_CODE(dac), .CHANNEL_ENABLE(chen), .SUPPLY_ENABLE(sup));
  analog_front_model i_front (.levels(lv), .chan_en(chen),
    .dac_code(dac), .cmp_out(cmp));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic peripheral_write_op(input logic rd, input logic [15:0] v);
    preq = '{wr: !rd, rd: rd, addr: DATA_PADDR, wdata: v};
    // The design loads the data register from the buffer pair
    if (!rd)
      dbuf = v;
    @(negedge clk);
    preq = '0;
  endtask : peripheral_write_op
  task automatic rf(input logic wr);
    rreq = '{wr: wr, rd: !wr, addr: START_RFADDR, wdata: 4'h1};
    @(negedge clk);
    rreq = '0;
  endtask : rf
  // Bounded wait for the supply gate to drop
  task automatic wait_idle(output int n);
    n = 0;
    repeat (2) @(negedge clk);
    while (sup !== 1'b0 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_idle
  function automatic logic [7:0] sar(input logic [7:0] l);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 7; b >= 0; b--)
      if (l > (r | (8'h1 << b)))
        r = r | (8'h1 << b);
    return r;
  endfunction : sar
  initial
  begin
    #250000;
    miscompares++;
    summarize;
  end
  initial
  begin
    logic [7:0] d;
    int         n;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 4; i++)
    begin
      lv = $random(seed);
      dbuf = $random(seed);
      ch = 2'(i);
      rreq = '{wr: 1'b1, rd: 1'b0, addr: START_RFADDR, wdata: 4'h1};
      @(negedge clk);
      rreq = '{wr: 1'b0, rd: 1'b1, addr: START_RFADDR, wdata: 4'h0};
      @(negedge clk);
      rreq = '0;
      check(16'(rrd), 16'h1);
      wait_idle(n);
      check(16'(n >= 90 && n <= 100), 16'h1);
      check(16'(done), 16'h1);
      peripheral_write_op(1'b1, 16'h0);
      check(prd, {dbuf[15:8], sar(lv[8*i +: 8])});
      rf(1'b0);
      check(16'(rrd), 16'h0);
    end
    $display("successive test ended");
    msel = 1'b1;
    repeat (6)
    begin
      lv = $random(seed);
      ch = 2'($random(seed));
      d = $random(seed);
      peripheral_write_op(1'b0, {8'($random(seed)), d});
      check(16'(dac), 16'(d));
      check(16'(cres), 16'h0);
      check(16'(chen), 16'(4'h1 << ch));
      wait_idle(n);
      check(16'(cres), 16'(lv[8*ch +: 8] > d));
    end
    $display("single test ended");
    msel = 1'b0;
    peripheral_write_op(1'b0, {8'h00, ~d});
    check(16'(dac), 16'(d));
    rf(1'b1);
    repeat (30) @(negedge clk);
    stop = 1'b1;
    @(negedge clk);
    check({7'h0, dac, sup}, 16'h0);
    stop = 1'b0;
    repeat (150) @(negedge clk);
    check({7'h0, dac, sup}, 16'h0);
    $display("stop test ended");
    rf(1'b1);
    repeat (30) @(negedge clk);
    halt = 1'b1;
    repeat (200) @(negedge clk);
    check({14'h0, sup, done}, 16'h2);
    halt = 1'b0;
    wait_idle(n);
    check(16'(done), 16'h1);
    $display("halt test ended");
    summarize;
  end
endmodule : sar_adc_sequencer_bench
